// ### verilog/fan_cfg_pkg.sv
// Constants and types for the fan-control configuration register bank
package fan_cfg_pkg;
  // Register map
  localparam logic [7:0] ADDR_CFG    = 8'h40;  // Ready/lock/apply/force register
  localparam logic [7:0] LIM_FIRST   = 8'h5c;  // First fan limit/parameter register
  localparam logic [7:0] LIM_LAST    = 8'h6e;  // Last fan limit/parameter register
  localparam int         NUM_LIM     = 19;     // Registers from first to last inclusive
  // Field positions in the configuration register
  localparam int         BIT_APPLY   = 0;      // Use programmed limits
  localparam int         BIT_LOCK    = 1;      // Freeze limits until power cycle
  localparam int         BIT_READY   = 2;      // Power-up done, converters running
  localparam int         BIT_FORCE   = 3;      // All PWM outputs at full duty
  localparam logic [7:0] CFG_RESET   = 8'h00;  // Register value after reset
  localparam logic [7:0] RD_UNMAPPED = 8'h00;  // Read value of any other address
  // Power-up settling time before the converters are trusted
  localparam int         CLK_NS      = 50;     // 20 MHz clock period
  localparam int         POR_TIME_NS = 1000;   // Least settling time
  localparam int         POR_CYCLES  = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int         POR_CW      = 5;      // Width of the settling counter
  localparam int         NUM_PWM     = 3;      // PWM channels

  // Configuration bits as held in hardware
  typedef struct packed {
    logic force_full;  // Full-speed force
    logic ready;       // Ready flag
    logic lock;        // Limit lock
    logic apply;       // Apply programmed settings
  } cfg_t;

  // Register write strobe with its address and data
  typedef struct packed {
    logic       wr;    // One-cycle write strobe
    logic [7:0] addr;  // Register address
    logic [7:0] data;  // Write data
  } reg_wr_t;

  // Power-up sequencing states, one-hot
  typedef enum logic [2:0] {
    PU_SETTLE = 3'b001,  // Waiting out the settling time
    PU_ADC    = 3'b010,  // Waiting for the converters
    PU_DONE   = 3'b100   // Ready flag raised
  } pu_state_t;
endpackage

// ### verilog/fan_cfg_bank.sv
// Fan-control configuration register and limit/parameter bank
`timescale 1ns/100ps
module fan_cfg_bank #(
  parameter logic [fan_cfg_pkg::NUM_LIM*8-1:0] DEFAULT_LIMITS = '0  // Built-in defaults
) (
  input  wire logic                                  CLK,
  input  wire logic                                  RESET,
  input  wire fan_cfg_pkg::reg_wr_t                  REG_WR,
  input  wire logic [7:0]                            RD_ADDR,
  output logic      [7:0]                            RD_DATA,
  input  wire logic                                  ADC_RUNNING,
  input  wire logic [fan_cfg_pkg::NUM_PWM-1:0]       PWM_IN,
  input  wire logic [fan_cfg_pkg::NUM_PWM-1:0]       PWM_DISABLE,
  output logic      [fan_cfg_pkg::NUM_PWM-1:0]       PWM_OUT,
  output logic      [fan_cfg_pkg::NUM_LIM*8-1:0]     EFF_LIMITS,
  output fan_cfg_pkg::cfg_t                          CFG
);
  import fan_cfg_pkg::*;

  cfg_t                        cfg_r, cfg_nxt;        // Configuration bits
  logic [7:0]                  lim_r   [NUM_LIM];     // Programmed limit registers
  logic [7:0]                  lim_nxt [NUM_LIM];     // Next limit values
  logic [NUM_LIM*8-1:0]        lim_flat;              // Limits as one vector
  logic [NUM_LIM*8-1:0]        eff_r, eff_nxt;        // Limits handed to fan logic
  logic [NUM_PWM-1:0]          pwm_r, pwm_nxt;        // Registered PWM outputs
  logic [7:0]                  rd_r, rd_nxt;          // Registered read data
  logic                        adc_s1_r, adc_s2_r;    // Converter status synchroniser
  pu_state_t                   pu_r, pu_nxt;          // Power-up sequence state
  logic [POR_CW-1:0]           por_cnt_r, por_cnt_nxt;// Settling counter
  logic                        wr_cfg;                // Write hits config register
  logic                        wr_lim;                // Write hits a limit register
  logic [7:0]                  wr_idx;                // Limit index of the write
  logic [7:0]                  rd_idx;                // Limit index of the read

  // Address decode; the subtraction gives the limit index, and two compares cover the range
  assign wr_idx = REG_WR.addr - LIM_FIRST;
  assign rd_idx = RD_ADDR - LIM_FIRST;
  assign wr_cfg = REG_WR.wr && (REG_WR.addr == ADDR_CFG);
  assign wr_lim = REG_WR.wr && (REG_WR.addr >= LIM_FIRST) && (REG_WR.addr <= LIM_LAST);

  // Flatten limits, register 0x5c in the low byte
  always_comb begin
    for (int i = 0; i < NUM_LIM; i++) begin
      lim_flat[i*8 +: 8] = lim_r[i];
    end
  end

  // Converter status comes from the analog side, so synchronise it first
  always_ff @(posedge CLK) begin
    if (RESET) begin
      adc_s1_r <= 1'b0;
      adc_s2_r <= 1'b0;
    end else begin
      adc_s1_r <= ADC_RUNNING;
      adc_s2_r <= adc_s1_r;
    end
  end

  // Power-up sequence: settle, then wait for converters, then raise ready
  always_comb begin
    pu_nxt      = pu_r;
    por_cnt_nxt = por_cnt_r;
    unique case (pu_r)
      PU_SETTLE: begin
        // Count out the settling time before trusting converter status
        if (por_cnt_r == POR_CW'(POR_CYCLES - 1)) begin
          pu_nxt = PU_ADC;
        end else begin
          por_cnt_nxt = por_cnt_r + POR_CW'(1);
        end
      end
      PU_ADC: begin
        // Converters must report running before the flag goes up
        if (adc_s2_r) begin
          pu_nxt = PU_DONE;
        end
      end
      PU_DONE: begin
        // Held until the next power-up reset
        pu_nxt = PU_DONE;
      end
      default: begin
        pu_nxt = PU_SETTLE;
      end
    endcase
  end

  // Sequence state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pu_r      <= PU_SETTLE;
      por_cnt_r <= '0;
    end else begin
      pu_r      <= pu_nxt;
      por_cnt_r <= por_cnt_nxt;
    end
  end

  // Configuration bits and limit registers, next values
  always_comb begin
    cfg_nxt = cfg_r;
    lim_nxt = lim_r;
    // Ready follows the sequencer only; software writes cannot touch it
    cfg_nxt.ready = (pu_nxt == PU_DONE);
    if (wr_cfg) begin
      // Apply and force stay writable even when locked
      cfg_nxt.apply      = REG_WR.data[BIT_APPLY];
      cfg_nxt.force_full = REG_WR.data[BIT_FORCE];
      // Lock can only be set; once set it ignores writes
      cfg_nxt.lock       = cfg_r.lock | REG_WR.data[BIT_LOCK];
    end
    // Limit writes are dropped while locked; the apply bit never touches them
    if (wr_lim && !cfg_r.lock) begin
      lim_nxt[wr_idx[4:0]] = REG_WR.data;
    end
  end

  // Configuration and limit registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_r <= cfg_t'(CFG_RESET[3:0]);
      for (int i = 0; i < NUM_LIM; i++) begin
        lim_r[i] <= 8'h00;
      end
    end else begin
      cfg_r <= cfg_nxt;
      lim_r <= lim_nxt;
    end
  end

  // Effective limits, PWM outputs and read data, next values
  always_comb begin
    // Defaults stay in force until software sets the apply bit
    eff_nxt = cfg_r.apply ? lim_flat : DEFAULT_LIMITS;
    // Force wins over the per-channel disable and the generator
    if (cfg_r.force_full) begin
      pwm_nxt = '1;
    end else begin
      pwm_nxt = PWM_IN & ~PWM_DISABLE;
    end
    // Read mux; reserved bits and unmapped addresses read zero
    if (RD_ADDR == ADDR_CFG) begin
      rd_nxt = {4'h0, 4'(cfg_r)};
    end else if ((RD_ADDR >= LIM_FIRST) && (RD_ADDR <= LIM_LAST)) begin
      rd_nxt = lim_r[rd_idx[4:0]];
    end else begin
      rd_nxt = RD_UNMAPPED;
    end
  end

  // Output registers; PWM is retimed here so outputs come from flops
  always_ff @(posedge CLK) begin
    if (RESET) begin
      eff_r <= '0;
      pwm_r <= '0;
      rd_r  <= 8'h00;
    end else begin
      eff_r <= eff_nxt;
      pwm_r <= pwm_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign EFF_LIMITS = eff_r;
  assign PWM_OUT    = pwm_r;
  assign RD_DATA    = rd_r;
  assign CFG        = cfg_r;

  // Checks
  sequence s_cfg_write;
    wr_cfg;
  endsequence

  sequence s_limits_held;
    ##1 (lim_flat == $past(lim_flat));
  endsequence

  property p_apply_sel;
    @(posedge CLK) disable iff (RESET) cfg_r.apply |=> (EFF_LIMITS == $past(lim_flat));
  endproperty
  a_apply_sel: assert property (p_apply_sel) else $error("apply set but limits not used");

  property p_default_sel;
    @(posedge CLK) disable iff (RESET) !cfg_r.apply |=> (EFF_LIMITS == DEFAULT_LIMITS);
  endproperty
  a_default_sel: assert property (p_default_sel) else $error("defaults not used");

  property p_keep_lim;
    @(posedge CLK) disable iff (RESET) s_cfg_write |-> s_limits_held;
  endproperty
  a_keep_lim: assert property (p_keep_lim) else $error("config write changed limits");

  property p_apply_free;
    @(posedge CLK) disable iff (RESET)
      (cfg_r.lock && wr_cfg) |=> (cfg_r.apply == $past(REG_WR.data[BIT_APPLY]));
  endproperty
  a_apply_free: assert property (p_apply_free) else $error("apply blocked by lock");

  property p_ready_cause;
    // Ready is registered one edge after the second sync flop is seen high
    @(posedge CLK) disable iff (RESET) $rose(cfg_r.ready) |-> $past(adc_s2_r);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without converters");

  property p_ready_sticky;
    @(posedge CLK) disable iff (RESET) cfg_r.ready |=> cfg_r.ready [*2];
  endproperty
  a_ready_sticky: assert property (p_ready_sticky) else $error("ready dropped");

  property p_force_full;
    @(posedge CLK) disable iff (RESET) cfg_r.force_full |=> (PWM_OUT == '1);
  endproperty
  a_force_full: assert property (p_force_full) else $error("force not at full duty");

  property p_pwm_normal;
    @(posedge CLK) disable iff (RESET)
      !cfg_r.force_full |=> (PWM_OUT == $past(PWM_IN & ~PWM_DISABLE));
  endproperty
  a_pwm_normal: assert property (p_pwm_normal) else $error("PWM pass-through wrong");

  property p_lock_freeze;
    @(posedge CLK) disable iff (RESET) (cfg_r.lock && wr_lim) |-> s_limits_held;
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked limit written");

  property p_lock_hold;
    @(posedge CLK) disable iff (RESET) cfg_r.lock |=> cfg_r.lock [*3];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock released");
endmodule

// ### testbench/test_fan_cfg_bank.sv
// Self-checking bench for the fan-control configuration register bank
`timescale 1ns/100ps
module test_fan_cfg_bank;
  import fan_cfg_pkg::*;
  localparam logic [NUM_LIM*8-1:0] DEF = {NUM_LIM{8'h3c}};  // Recognisable built-in set
  logic                   CLK, RESET, ADC_RUNNING;
  reg_wr_t                REG_WR;
  logic [7:0]             RD_ADDR, RD_DATA;
  logic [NUM_PWM-1:0]     PWM_IN, PWM_DISABLE, PWM_OUT;
  logic [NUM_LIM*8-1:0]   EFF_LIMITS;
  cfg_t                   CFG;
  int                     errors, tests_run, n;
  logic                   m_apply, m_lock, m_force, m_ready;  // Expected config bits
  logic [7:0]             m_lim [NUM_LIM];                   // Expected stored limits

  fan_cfg_bank #(.DEFAULT_LIMITS(DEF)) i_dut (.CLK(CLK), .RESET(RESET), .REG_WR(REG_WR),
    .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .ADC_RUNNING(ADC_RUNNING), .PWM_IN(PWM_IN),
    .PWM_DISABLE(PWM_DISABLE), .PWM_OUT(PWM_OUT), .EFF_LIMITS(EFF_LIMITS), .CFG(CFG));

  // 20 MHz clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Byte-sized results
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Whole effective limit vector
  task automatic chk_lim(input logic [NUM_LIM*8-1:0] got, input logic [NUM_LIM*8-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_cfg();
    return {4'h0, m_force, m_ready, m_lock, m_apply};
  endfunction

  // Programmed set only while apply is on, otherwise the built-in set
  function automatic logic [NUM_LIM*8-1:0] exp_lim();
    logic [NUM_LIM*8-1:0] v;
    for (int i = 0; i < NUM_LIM; i++) v[i*8+:8] = m_lim[i];
    return m_apply ? v : DEF;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(negedge CLK);
  endtask

  // Two cycles a write so the strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR = '{wr: 1'b1, addr: a, data: d};
    cyc(1);
    REG_WR.wr = 1'b0;
    if (a >= LIM_FIRST && a <= LIM_LAST && !m_lock) m_lim[a-LIM_FIRST] = d;
    if (a == ADDR_CFG) begin
      m_apply = d[BIT_APPLY];
      m_force = d[BIT_FORCE];
      m_lock  = m_lock | d[BIT_LOCK];  // Lock only ever sets
    end
    cyc(1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    RD_ADDR = a;
    cyc(1);
    chk8(RD_DATA, exp);
  endtask

  task automatic lim_all(input bit check);
    for (int i = 0; i < NUM_LIM; i++)
      if (check) rdc(8'(LIM_FIRST + i), m_lim[i]);
      else wr(8'(LIM_FIRST + i), 8'($urandom));
  endtask

  // Random PWM samples, checked one cycle later
  task automatic pwm(input int k);
    logic [NUM_PWM-1:0] e;
    repeat (k) begin
      PWM_IN      = 3'($urandom);
      PWM_DISABLE = 3'($urandom);
      e = m_force ? '1 : (PWM_IN & ~PWM_DISABLE);
      cyc(1);
      chk8(8'(PWM_OUT), 8'(e));
    end
  endtask

  // Power-up reset clears every expectation
  task automatic do_reset;
    RESET = 1'b1;
    {m_apply, m_lock, m_force, m_ready} = 4'h0;
    foreach (m_lim[i]) m_lim[i] = 8'h00;
    cyc(20);
    RESET = 1'b0;
  endtask

  // Watchdog against a hang
  initial begin
    #(50 * 8000);
    errors++;
    finish_test();
  end

  initial begin
    ADC_RUNNING = 1'b0;
    REG_WR      = '0;
    RD_ADDR     = 8'h00;
    PWM_IN      = '0;
    PWM_DISABLE = '0;
    errors      = 0;
    tests_run   = 0;
    void'($urandom(32'hd8a5));
    // Reset is raised at time zero and held for exactly twenty edges
    do_reset();
    cyc(1);
    chk_lim(EFF_LIMITS, exp_lim());
    wr(ADDR_CFG, 8'h04);
    cyc(30);
    rdc(ADDR_CFG, exp_cfg());
    do_reset();
    ADC_RUNNING = 1'b1;
    n = 0;
    while (CFG.ready !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk8(8'(n >= POR_CYCLES && n < POR_CYCLES + 8), 8'h01);
    m_ready = 1'b1;
    rdc(ADDR_CFG, exp_cfg());
    // Host fills every limit before it turns the apply bit on
    lim_all(0);
    chk_lim(EFF_LIMITS, exp_lim());
    wr(ADDR_CFG, 8'h01);
    chk_lim(EFF_LIMITS, exp_lim());
    lim_all(1);
    wr(ADDR_CFG, 8'h00);
    chk_lim(EFF_LIMITS, exp_lim());
    lim_all(1);
    // Writes just outside the limit range must land nowhere
    wr(8'h5b, 8'hff);
    wr(8'h6f, 8'hff);
    rdc(8'h41, RD_UNMAPPED);
    rdc(8'h5b, RD_UNMAPPED);
    rdc(8'h6f, RD_UNMAPPED);
    lim_all(1);
    pwm(16);
    wr(ADDR_CFG, 8'h08);
    pwm(16);
    wr(ADDR_CFG, 8'h0b);
    lim_all(0);
    lim_all(1);
    chk_lim(EFF_LIMITS, exp_lim());
    wr(ADDR_CFG, 8'h00);
    rdc(ADDR_CFG, exp_cfg());
    chk8(8'(CFG), exp_cfg());
    chk_lim(EFF_LIMITS, exp_lim());
    pwm(8);
    wr(ADDR_CFG, 8'h09);
    pwm(8);
    chk8(8'(CFG), exp_cfg());
    chk_lim(EFF_LIMITS, exp_lim());
    do_reset();
    rdc(ADDR_CFG, exp_cfg());
    rdc(LIM_FIRST, 8'h00);
    wr(LIM_FIRST, 8'h5a);
    rdc(LIM_FIRST, 8'h5a);
    finish_test();
  end
endmodule
